// ### cpu_seq_model.sv
// Stand-in for the CPU sequencer: marks instruction boundaries.
// Assumes the block stalls it through ack_busy.
`timescale 1ns/100ps
module cpu_seq_model (
	input	wire logic	clk_sys,
	input	wire logic	rst,
	input	wire logic	ack_busy,
	input	wire logic	slow,
	output	logic		instr_done
);
	logic [1:0] cnt_q;
	always_ff @(posedge clk_sys) begin
		cnt_q <= (rst || cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
	end
	// Slow mode: three-clock instructions
	assign instr_done = !rst && !ack_busy && (!slow || cnt_q == 2'h0);
endmodule // cpu_seq_model

// ### irq_accept.sv
// Maskable and software interrupt acceptance with status word, flags, masks and priorities.
// Assumes the CPU sequencer pulses instr_done at boundaries and stalls while ack_busy is high.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
module irq_accept
	import irq_accept_pkg::*;
#(
	parameter int N   = SRC_COUNT,
	parameter int IDX = $clog2(SRC_COUNT)
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [N-1:0]     src_event,
	input  wire logic [2:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	input  wire logic             instr_done,
	input  wire logic             instr_is_hold,
	input  wire logic             op_brk,
	input  wire logic             op_ei,
	input  wire logic             op_di,
	input  wire logic             op_restore,
	input  wire logic [7:0]       restore_status,
	input  wire logic             nmi_in_service,
	output logic      [7:0]       status_word,
	output logic      [7:0]       edge_mode,
	output logic                  ack_busy,
	output logic                  push_status_stb,
	output logic                  push_pc_stb,
	output logic      [7:0]       push_data,
	output logic                  vector_load,
	output logic      [15:0]      vector_addr
);

	typedef struct packed {
		logic [N-1:0]      flag;
		logic [N-1:0]      mask;
		logic [N-1:0]      prio;
		logic [7:0]        status;
		logic [7:0]        edge_mode;
		logic              hold_arm;
		ack_state_t        st;
		logic [WAIT_W-1:0] cnt;
		logic [15:0]       vec;
		logic [7:0]        saved;
		logic [7:0]        rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [N-1:0]   eligible;
	logic [N-1:0]   level_high_req;
	logic [N-1:0]   level_low_req;
	logic           high_any;
	logic           low_any;
	logic [IDX-1:0] high_idx;
	logic [IDX-1:0] low_idx;
	logic           win_any;
	logic [IDX-1:0] win_idx;
	logic           win_prio;
	logic           level_ok;
	logic           hold_hit;
	logic           boundary_blocked;
	logic [N-1:0]   win_onehot;

	assign eligible       = s_q.flag & ~s_q.mask;
	assign level_high_req = eligible & ~s_q.prio;
	assign level_low_req  = eligible & s_q.prio;

	irq_rank_encoder #(
		.W   (N),
		.IDX (IDX)
	) u_rank_high (
		.req (level_high_req),
		.any (high_any),
		.idx (high_idx)
	);

	irq_rank_encoder #(
		.W   (N),
		.IDX (IDX)
	) u_rank_low (
		.req (level_low_req),
		.any (low_any),
		.idx (low_idx)
	);

	// High level first, default rank only breaks ties within a level
	assign win_any  = high_any | low_any;
	assign win_idx  = high_any ? high_idx : low_idx;
	assign win_prio = ~high_any;

	// Low level passes only while no high-level handler is in service
	assign level_ok = s_q.status[ISP_BIT] | ~win_prio;

	// Writes to flag, mask, priority, edge mode and status registers hold acceptance
	always_comb begin
		hold_hit = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				OFS_FLAGS_LOW, OFS_FLAGS_HIGH, OFS_MASK_LOW, OFS_MASK_HIGH,
				OFS_PRIO_LOW, OFS_PRIO_HIGH, OFS_EDGE_MODE, OFS_STATUS: hold_hit = 1'b1;
				default: hold_hit = 1'b0;
			endcase
		end
	end

	assign boundary_blocked = instr_is_hold | s_q.hold_arm | hold_hit;

	generate
		for (genvar g = 0; g < N; g++) begin : g_onehot
			assign win_onehot[g] = (win_idx == IDX'(g));
		end
	endgenerate

	always_comb begin
		logic [REG_W-1:0] f16;
		logic [REG_W-1:0] m16;
		logic [REG_W-1:0] p16;
		logic [7:0]       rd;
		logic             take;

		s_d  = s_q;
		f16  = {{(REG_W - N){1'b0}}, s_q.flag};
		m16  = {{(REG_W - N){1'b1}}, s_q.mask};
		p16  = {{(REG_W - N){1'b1}}, s_q.prio};
		rd   = '0;
		take = 1'b0;

		// Read data valid only in the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				OFS_FLAGS_LOW:  rd = f16[BYTE_W-1:0];
				OFS_FLAGS_HIGH: rd = f16[REG_W-1:BYTE_W];
				OFS_MASK_LOW:   rd = m16[BYTE_W-1:0];
				OFS_MASK_HIGH:  rd = m16[REG_W-1:BYTE_W];
				OFS_PRIO_LOW:   rd = p16[BYTE_W-1:0];
				OFS_PRIO_HIGH:  rd = p16[REG_W-1:BYTE_W];
				OFS_EDGE_MODE:  rd = s_q.edge_mode;
				OFS_STATUS:     rd = s_q.status;
				default:        rd = '0;
			endcase
		end
		s_d.rdata = rd;

		if (reg_wr) begin
			case (reg_addr)
				OFS_FLAGS_LOW:  f16[BYTE_W-1:0]     = reg_wdata;
				OFS_FLAGS_HIGH: f16[REG_W-1:BYTE_W] = reg_wdata;
				OFS_MASK_LOW:   m16[BYTE_W-1:0]     = reg_wdata;
				OFS_MASK_HIGH:  m16[REG_W-1:BYTE_W] = reg_wdata;
				OFS_PRIO_LOW:   p16[BYTE_W-1:0]     = reg_wdata;
				OFS_PRIO_HIGH:  p16[REG_W-1:BYTE_W] = reg_wdata;
				OFS_EDGE_MODE:  s_d.edge_mode       = reg_wdata;
				OFS_STATUS:     s_d.status          = reg_wdata;
				default:        ;
			endcase
		end
		s_d.mask = m16[N-1:0];
		s_d.prio = p16[N-1:0];

		// Status word: register write wins, then enable instructions, then stack restore
		if (!(reg_wr && reg_addr == OFS_STATUS)) begin
			if (op_restore) begin
				s_d.status = restore_status;
			end
			if (op_ei) begin
				s_d.status[IE_BIT] = 1'b1;
			end else if (op_di) begin
				s_d.status[IE_BIT] = 1'b0;
			end
		end

		if (instr_done) begin
			s_d.hold_arm = 1'b0;
		end else if (hold_hit) begin
			s_d.hold_arm = 1'b1;
		end

		unique case (s_q.st)
			ST_IDLE: begin
				if (instr_done && op_brk) begin
					// Trap cannot be disabled; its enable clear blocks maskable ones
					s_d.saved          = s_q.status;
					s_d.status[IE_BIT] = 1'b0;
					s_d.vec            = TRAP_VECTOR;
					s_d.st             = ST_PUSH_STATUS;
				end else if (instr_done && !boundary_blocked && win_any && s_q.status[IE_BIT]
				             && !nmi_in_service && level_ok) begin
					take                = 1'b1;
					s_d.saved           = s_q.status;
					s_d.status[IE_BIT]  = 1'b0;
					s_d.status[ISP_BIT] = win_prio;
					s_d.vec             = VECTOR_BASE + VECTOR_STRIDE * {{(16 - IDX){1'b0}}, win_idx};
					s_d.cnt             = win_prio ? WAIT_LOW : WAIT_HIGH;
					s_d.st              = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (s_q.cnt == '0) begin
					s_d.st = ST_PUSH_STATUS;
				end else begin
					s_d.cnt = s_q.cnt - WAIT_W'(1);
				end
			end
			ST_PUSH_STATUS: s_d.st = ST_PUSH_PC;
			ST_PUSH_PC:     s_d.st = ST_LOAD;
			ST_LOAD:        s_d.st = ST_IDLE;
		endcase

		// Event set wins over both the accept clear and a software clear
		if (take) begin
			f16[N-1:0] = f16[N-1:0] & ~win_onehot;
		end
		s_d.flag = f16[N-1:0] | src_event;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q.flag      <= '0;
			s_q.mask      <= {N{MASK_RESET[0]}};
			s_q.prio      <= {N{PRIO_RESET[0]}};
			s_q.status    <= STATUS_RESET;
			s_q.edge_mode <= EDGE_RESET;
			s_q.hold_arm  <= 1'b0;
			s_q.st        <= ST_IDLE;
			s_q.cnt       <= '0;
			s_q.vec       <= '0;
			s_q.saved     <= '0;
			s_q.rdata     <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Acceptance waits for instr_done, so a long divide stretches the delay
	assign ack_busy        = (s_q.st != ST_IDLE);
	assign push_status_stb = (s_q.st == ST_PUSH_STATUS);
	assign push_pc_stb     = (s_q.st == ST_PUSH_PC);
	assign vector_load     = (s_q.st == ST_LOAD);
	assign push_data       = s_q.saved;
	assign vector_addr     = s_q.vec;
	assign status_word     = s_q.status;
	assign edge_mode       = s_q.edge_mode;
	assign reg_rdata       = s_q.rdata;

endmodule // irq_accept

// ### irq_accept_pkg.sv
// Constants, register offsets and types shared by the interrupt acceptance logic.
// Assumes an 8-bit register port and a CPU sequencer that marks instruction boundaries.
package irq_accept_pkg;

	localparam int          SRC_COUNT      = 12;
	localparam int          REG_W          = 16;
	localparam int          BYTE_W         = 8;

	// Register port byte offsets
	localparam logic [2:0]  OFS_FLAGS_LOW  = 3'h0;
	localparam logic [2:0]  OFS_FLAGS_HIGH = 3'h1;
	localparam logic [2:0]  OFS_MASK_LOW   = 3'h2;
	localparam logic [2:0]  OFS_MASK_HIGH  = 3'h3;
	localparam logic [2:0]  OFS_PRIO_LOW   = 3'h4;
	localparam logic [2:0]  OFS_PRIO_HIGH  = 3'h5;
	localparam logic [2:0]  OFS_EDGE_MODE  = 3'h6;
	localparam logic [2:0]  OFS_STATUS     = 3'h7;

	// Reset values
	localparam logic [7:0]  STATUS_RESET   = 8'h02;
	localparam logic [7:0]  MASK_RESET     = 8'hff;
	localparam logic [7:0]  PRIO_RESET     = 8'hff;
	localparam logic [7:0]  EDGE_RESET     = 8'h00;

	// Status word fields
	localparam int          IE_BIT         = 7;
	localparam int          ISP_BIT        = 1;

	// Vectors
	localparam logic [15:0] TRAP_VECTOR    = 16'h003e;
	localparam logic [15:0] VECTOR_BASE    = 16'h0004;
	localparam logic [15:0] VECTOR_STRIDE  = 16'h0002;

	// Least acceptance time in clocks, per programmable level
	localparam int          MIN_CLK_HIGH   = 7;
	localparam int          MIN_CLK_LOW    = 8;
	// Flag setting, decision, two pushes: cycles outside the wait state
	localparam int          ACK_OVERHEAD   = 4;
	localparam int          WAIT_W         = 3;
	localparam logic [WAIT_W-1:0] WAIT_HIGH = WAIT_W'(MIN_CLK_HIGH - ACK_OVERHEAD - 1);
	localparam logic [WAIT_W-1:0] WAIT_LOW  = WAIT_W'(MIN_CLK_LOW - ACK_OVERHEAD - 1);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_PUSH_STATUS,
		ST_PUSH_PC,
		ST_LOAD
	} ack_state_t;

endpackage

// ### irq_accept_sva.sv
// Port assertions for the acceptance block.
// Assumes one clock and a sequencer that stalls on ack_busy.
`timescale 1ns/100ps
module irq_accept_chk (
	input	wire logic		clk_sys,
	input	wire logic		rst,
	input	wire logic		instr_done,
	input	wire logic		instr_is_hold,
	input	wire logic		op_brk,
	input	wire logic		nmi_in_service,
	input	wire logic [7:0]	status_word,
	input	wire logic		ack_busy,
	input	wire logic		push_status_stb,
	input	wire logic		push_pc_stb,
	input	wire logic [7:0]	push_data,
	input	wire logic		vector_load,
	input	wire logic [15:0]	vector_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic plain_bnd = instr_done && !op_brk && !ack_busy;
	reset_status_a: assert property ($fell(rst) |-> status_word == 8'h02)
		else $error("status word not at reset value");
	ack_entry_a: assert property ($rose(ack_busy) |-> push_data == $past(status_word) && !status_word[7])
		else $error("saved status or enable clear wrong");
	ie_block_a: assert property (plain_bnd && !status_word[7] |=> !ack_busy)
		else $error("accepted with enable clear");
	hold_block_a: assert property (plain_bnd && instr_is_hold |=> !ack_busy)
		else $error("accepted at hold boundary");
	nmi_block_a: assert property (plain_bnd && nmi_in_service |=> !ack_busy)
		else $error("accepted during non-maskable service");
	mask_wait_a: assert property ($rose(ack_busy) && !$past(op_brk) |-> !push_status_stb [*3] ##[1:2] push_status_stb)
		else $error("maskable push timing wrong");
	trap_seq_a: assert property (instr_done && op_brk && !ack_busy |=> push_status_stb ##1 push_pc_stb ##1 (vector_load && vector_addr == 16'h003e))
		else $error("trap sequence wrong");
	push_order_a: assert property (push_status_stb |=> push_pc_stb ##1 vector_load)
		else $error("push order wrong");
	busy_end_a: assert property (vector_load |-> ack_busy ##1 !ack_busy)
		else $error("busy not ending at vector load");
endmodule // irq_accept_chk
bind irq_accept irq_accept_chk chk (.clk_sys(clk_sys), .rst(rst), .instr_done(instr_done),
	.instr_is_hold(instr_is_hold), .op_brk(op_brk), .nmi_in_service(nmi_in_service), .status_word(status_word),
	.ack_busy(ack_busy), .push_status_stb(push_status_stb), .push_pc_stb(push_pc_stb), .push_data(push_data),
	.vector_load(vector_load), .vector_addr(vector_addr));

// ### irq_rank_encoder.sv
// Fixed-rank priority encoder: lowest index is the highest default rank.
// Assumes a request vector from logic on the same clock.
`timescale 1ns/100ps
module irq_rank_encoder #(
	parameter int W   = 12,
	parameter int IDX = 4
) (
	input  wire logic [W-1:0]   req,
	output logic                any,
	output logic [IDX-1:0]      idx
);

	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = IDX'(i);
			end
		end
	end

endmodule // irq_rank_encoder

// ### tb_top.sv
// Self-checking bench for the acceptance block.
// Assumes the sequencer model drives instr_done; a monitor checks queued notes.
`timescale 1ns/100ps
module tb_top;
	import irq_accept_pkg::*;
	typedef struct {logic [15:0] a; int at;} note_t;
	logic clk_sys, rst, reg_wr, reg_rd, instr_done, instr_is_hold, op_brk, op_ei, op_di, op_restore, rd_d;
	logic nmi_in_service, ack_busy, push_status_stb, push_pc_stb, vector_load, slow;
	logic [11:0] src_event, pr;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, restore_status, status_word, edge_mode, push_data;
	logic [15:0] vector_addr;
	logic [7:0] rv [8] = '{8'h00, 8'h00, MASK_RESET, MASK_RESET, PRIO_RESET, PRIO_RESET, EDGE_RESET, STATUS_RESET};
	int cyc = 0, fail_count = 0, cmp_count = 0, e, s, b, w;
	note_t vq[$];
	logic [7:0] rq[$];
	irq_accept uut (.clk_sys(clk_sys), .rst(rst), .src_event(src_event), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_done(instr_done),
		.instr_is_hold(instr_is_hold), .op_brk(op_brk), .op_ei(op_ei), .op_di(op_di), .op_restore(op_restore),
		.restore_status(restore_status), .nmi_in_service(nmi_in_service), .status_word(status_word),
		.edge_mode(edge_mode), .ack_busy(ack_busy), .push_status_stb(push_status_stb), .push_pc_stb(push_pc_stb),
		.push_data(push_data), .vector_load(vector_load), .vector_addr(vector_addr));
	cpu_seq_model seq (.clk_sys(clk_sys), .rst(rst), .ack_busy(ack_busy), .slow(slow), .instr_done(instr_done));
	task automatic bad(input string m);
		fail_count++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask
	task automatic summarize;
		if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [15:0] vec(input int i);
		return VECTOR_BASE + VECTOR_STRIDE * 16'(i);
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] x);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(x);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask
	task automatic fire(input logic [11:0] m);
		@(posedge clk_sys);
		src_event <= m;
		e = cyc + 1;
		@(posedge clk_sys);
		src_event <= '0;
	endtask
	task automatic ret(input logic [7:0] v, input logic h);
		@(posedge clk_sys);
		op_restore <= 1'b1;
		restore_status <= v;
		instr_is_hold <= h;
		e = cyc + 1;
		@(posedge clk_sys);
		op_restore <= 1'b0;
		instr_is_hold <= 1'b0;
	endtask
	task automatic expv(input logic [15:0] a, input int at);
		vq.push_back('{a, at});
	endtask
	task automatic idle;
		int n;
		n = 0;
		while (vq.size() > 0 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 100) bad("no vector load");
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic setpr(input logic [11:0] p);
		wr(OFS_PRIO_LOW, p[7:0]);
		wr(OFS_PRIO_HIGH, {4'h0, p[11:8]});
	endtask
	task automatic chk_rd;
		logic [7:0] x;
		cmp_count++;
		if (rq.size() == 0) bad("stray read data");
		else begin
			x = rq.pop_front();
			if (reg_rdata !== x) bad("read data mismatch");
		end
	endtask
	task automatic chk_vec;
		note_t n;
		cmp_count++;
		if (vq.size() == 0) bad("unexpected vector load");
		else begin
			n = vq.pop_front();
			if (vector_addr !== n.a || (n.at >= 0 && n.at != cyc)) bad("vector or timing mismatch");
		end
	endtask
	task automatic chk_edge(input logic [7:0] x);
		cmp_count++;
		if (edge_mode !== x) bad("edge mode output mismatch");
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		rd_d <= reg_rd;
		if (rd_d === 1'b1) chk_rd();
		if (vector_load === 1'b1) chk_vec();
	end
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		bad("watchdog expired");
		summarize();
	end
	initial begin
		{src_event, reg_addr, reg_wdata, reg_wr, reg_rd, instr_is_hold, op_brk, op_ei, op_di} = '0;
		{op_restore, restore_status, nmi_in_service, slow} = '0;
		rst = 1'b1;
		void'($urandom(32'ha0e4));
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		for (int k = 0; k < 8; k++) rd(3'(k), rv[k]);
		wr(OFS_MASK_LOW, 8'h00);
		wr(OFS_MASK_HIGH, 8'h00);
		@(posedge clk_sys);
		op_ei <= 1'b1;
		@(posedge clk_sys);
		op_ei <= 1'b0;
		repeat (6) begin
			pr = 12'($urandom);
			s = $urandom_range(11, 0);
			setpr(pr);
			fire(12'h001 << s);
			expv(vec(s), e + 7 + pr[s]);
			idle();
			rd(OFS_STATUS, {6'h00, pr[s], 1'b0});
			rd(OFS_FLAGS_LOW, 8'h00);
			rd(OFS_FLAGS_HIGH, 8'h00);
			ret(8'h82, 1'b0);
		end
		repeat (4) begin
			pr = 12'($urandom);
			s = $urandom_range(11, 0);
			b = (s + 1 + $urandom_range(10, 0)) % 12;
			setpr(pr);
			fire((12'h001 << s) | (12'h001 << b));
			w = (pr[s] != pr[b]) ? (pr[s] ? b : s) : (s < b ? s : b);
			expv(vec(w), e + 7 + pr[w]);
			idle();
			ret(8'h82, 1'b1);
			expv(vec(s + b - w), e + 7 + pr[s + b - w]);
			idle();
			ret(8'h82, 1'b0);
		end
		setpr(12'h008);
		wr(OFS_MASK_LOW, 8'h08);
		fire(12'h008);
		repeat (20) @(posedge clk_sys);
		rd(OFS_FLAGS_LOW, 8'h08);
		slow <= 1'b1;
		wr(OFS_MASK_LOW, 8'h00);
		expv(vec(3), -1);
		idle();
		slow <= 1'b0;
		ret(8'h82, 1'b0);
		@(posedge clk_sys);
		op_brk <= 1'b1;
		src_event <= 12'h001;
		e = cyc + 1;
		@(posedge clk_sys);
		op_brk <= 1'b0;
		src_event <= '0;
		expv(TRAP_VECTOR, e + 3);
		repeat (20) @(posedge clk_sys);
		rd(OFS_STATUS, 8'h02);
		@(posedge clk_sys);
		op_ei <= 1'b1;
		e = cyc + 1;
		@(posedge clk_sys);
		op_ei <= 1'b0;
		expv(vec(0), e + 7);
		idle();
		ret(8'h82, 1'b0);
		ret(8'h80, 1'b0);
		fire(12'h008);
		repeat (20) @(posedge clk_sys);
		fire(12'h020);
		expv(vec(5), e + 7);
		idle();
		ret(8'h82, 1'b0);
		expv(vec(3), e + 8);
		idle();
		ret(8'h82, 1'b0);
		@(posedge clk_sys);
		nmi_in_service <= 1'b1;
		fire(12'h001);
		repeat (20) @(posedge clk_sys);
		nmi_in_service <= 1'b0;
		e = cyc + 1;
		expv(vec(0), e + 6);
		idle();
		ret(8'h82, 1'b0);
		fire(12'h001);
		instr_is_hold <= 1'b1;
		@(posedge clk_sys);
		instr_is_hold <= 1'b0;
		expv(vec(0), e + 8);
		idle();
		ret(8'h82, 1'b0);
		w = $urandom_range(255, 0);
		@(posedge clk_sys);
		src_event <= 12'h001;
		e = cyc + 1;
		@(posedge clk_sys);
		src_event <= '0;
		reg_addr <= OFS_EDGE_MODE;
		reg_wdata <= 8'(w);
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// Register write at the first eligible boundary defers acceptance by one
		expv(vec(0), e + 8);
		idle();
		chk_edge(8'(w));
		rd(OFS_EDGE_MODE, 8'(w));
		ret(8'h82, 1'b0);
		@(posedge clk_sys);
		op_di <= 1'b1;
		@(posedge clk_sys);
		op_di <= 1'b0;
		fire(12'h001);
		repeat (10) @(posedge clk_sys);
		rd(OFS_FLAGS_LOW, 8'h01);
		rd(OFS_STATUS, 8'h02);
		repeat (2) @(posedge clk_sys);
		if (vq.size() != 0 || rq.size() != 0) bad("results missing");
		summarize();
	end
endmodule // tb_top
